// file: rtl/zero_crossing_interval_timer.sv
// interval timer top: mode control, gating, time base, display and count outputs
`timescale 1ns/1ps
// Summary of operation
// - single internal: count time base from start to first following stop, then hold.
// - external modes count external clock pulses, same gating as internal mode.
// - single modes: start/stop both B, both C, or start B stop C.
// - multiple and continuous: start and stop from one channel, B or C.
// - multiple internal counts 1, 10 or 100 MHz over N intervals.
// - multiple external counts external pulses until first stop after N starts.
// - multiple internal result in microseconds with automatic decimal point.
// - continuous: measure every interval, auto reset on each stop.
// - continuous: 1000 counts of the counted input (time base, or external clock in external mode) elapse before the gate reopens.
// - single and multiple never clear automatically; only explicit reset clears.
// - a stop pulse cannot restart counting; in continuous mode a new start is needed after the holdoff.
// - result shown as eight decimal digits with automatic decimal point.
// - local reset request clears the displayed result at any time.
// - gate lamp on while gate open; forced open keeps it on.
// - holding on: display updates at completion; off: shows running count.
// - time base from internal 1 MHz or external 1 MHz reference.
// - time base divided in decade steps, decade selectable.
// - single/multiple internal output scaled time base; multiple also scaled input.
// - primary output: bcd digits, decimal point, reset inhibit, end of count.
// - secondary output: complements of primary, without decimal point and inhibit.
module zero_crossing_interval_timer (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic marker_b,
    input wire logic marker_c,
    input wire logic ext_clk,
    input wire logic ext_ref,
    input wire logic clear_req,
    output logic [31:0] bcd_out,
    output logic [1:0] dp_out,
    output logic rst_inhibit,
    output logic eoc,
    output logic [31:0] bcd_out_n,
    output logic eoc_n,
    output logic gate_lamp,
    output logic tb_out,
    output logic sig_scaled_out
);
    // pin synchronisers; third stage only serves the edge detect
    logic [4:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_rise;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
            pin_s3_r <= 5'h00;
        end else begin
            pin_s1_r <= {clear_req, ext_ref, ext_clk, marker_c, marker_b};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end
    assign pin_rise = pin_s2_r & ~pin_s3_r;

    // register slave: one wait state per access
    interval_pkg::ctrl_s ctrl_r, ctrl_nxt;
    interval_pkg::state_e state_r, state_nxt;
    logic [15:0] nint_r, nint_nxt, seen_r, seen_nxt;
    logic [31:0] rdata_r, rdata_nxt, count_q, disp_r, disp_nxt;
    logic waitreq_r, waitreq_nxt, cmd_clr, ovf_r, ovf_nxt, gate_open, eoc_p;

    always_comb begin
        ctrl_nxt = ctrl_r;
        nint_nxt = nint_r;
        rdata_nxt = rdata_r;
        cmd_clr = 1'b0;
        waitreq_nxt = !((avs_read || avs_write) && waitreq_r);
        if (avs_write && !waitreq_r) begin
            if (avs_address == interval_pkg::OFS_CTRL) begin
                ctrl_nxt = interval_pkg::ctrl_s'(avs_writedata[interval_pkg::CTRL_W-1:0]);
            end else if (avs_address == interval_pkg::OFS_NINT) begin
                nint_nxt = avs_writedata[15:0];
            end else if (avs_address == interval_pkg::OFS_CMD) begin
                cmd_clr = avs_writedata[0];
            end
        end
        if (avs_read && waitreq_r) begin
            if (avs_address == interval_pkg::OFS_CTRL) begin
                rdata_nxt = {20'h0_0000, ctrl_r};
            end else if (avs_address == interval_pkg::OFS_NINT) begin
                rdata_nxt = {16'h0000, nint_r};
            end else if (avs_address == interval_pkg::OFS_STAT) begin
                rdata_nxt = {seen_r, 12'h000, ovf_r, gate_open, state_r};
            end else if (avs_address == interval_pkg::OFS_COUNT) begin
                rdata_nxt = count_q;
            end else if (avs_address == interval_pkg::OFS_DISP) begin
                rdata_nxt = disp_r;
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_r <= interval_pkg::CTRL_RST;
            nint_r <= interval_pkg::NINT_RST;
            rdata_r <= 32'h0000_0000;
            waitreq_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            nint_r <= nint_nxt;
            rdata_r <= rdata_nxt;
            waitreq_r <= waitreq_nxt;
        end
    end
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = waitreq_r;

    // mode decode; undefined codes fall back to single
    function automatic logic [1:0] dp_of(input logic [3:0] rate, input logic ext);
        logic [3:0] r3;
        r3 = rate % 4'h3;
        return ext ? interval_pkg::DP_NONE : 2'h2 - r3[1:0];
    endfunction

    logic is_ext, is_mult, is_cont, is_single, ext_edge, clr_any, start_p, stop_p;
    logic [3:0] rate_eff;
    logic [15:0] nint_eff;
    assign is_ext = ctrl_r.mode[0];
    assign is_mult = ctrl_r.mode[2:1] == 2'b01;
    assign is_cont = ctrl_r.mode[2:1] == 2'b10;
    assign is_single = !is_mult && !is_cont;
    assign ext_edge = pin_rise[2];
    assign clr_any = cmd_clr || pin_rise[4];
    assign nint_eff = (nint_r == 16'h0000) ? 16'h0001 : nint_r;
    assign rate_eff = is_mult ?
        ((ctrl_r.rate > interval_pkg::MULT_RATE_MAX) ? interval_pkg::MULT_RATE_MAX : ctrl_r.rate) :
        ((ctrl_r.rate > interval_pkg::RATE_MAX) ? interval_pkg::RATE_MAX : ctrl_r.rate);
    // split channels only in single modes; otherwise one channel carries both
    assign start_p = (ctrl_r.sel == interval_pkg::SEL_C) ? pin_rise[1] : pin_rise[0];
    assign stop_p = (is_single && ctrl_r.sel == interval_pkg::SEL_BC) ? pin_rise[1] : start_p;

    // time base: 1 MHz tick, 10 MHz tick and a 2/3 pattern that averages 100 MHz
    logic [5:0] div_r, div_nxt;
    logic [1:0] fast_r, fast_nxt, inc_int, inc_sel, cnt_inc;
    logic phase_r, tick_int, tb_1m;
    logic [interval_pkg::DEC_N:0] dec_ticks;
    assign tick_int = div_r == interval_pkg::TB_DIV_LAST;
    assign tb_1m = ctrl_r.ref_ext ? pin_rise[3] : tick_int;
    always_comb begin
        div_nxt = tick_int ? 6'h00 : div_r + 6'h01;
        fast_nxt = (fast_r == interval_pkg::FAST_DIV_LAST) ? 2'h0 : fast_r + 2'h1;
        if (rate_eff == 4'h0) begin
            inc_int = phase_r ? 2'h3 : 2'h2;
        end else if (rate_eff == 4'h1) begin
            inc_int = {1'b0, fast_r == interval_pkg::FAST_DIV_LAST};
        end else begin
            inc_int = {1'b0, dec_ticks[3'(rate_eff - 4'h2)]};
        end
        inc_sel = is_ext ? {1'b0, ext_edge} : inc_int;
        cnt_inc = (gate_open && !eoc_p) ? inc_sel : 2'h0;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_r <= 6'h00;
            fast_r <= 2'h0;
            phase_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            fast_r <= fast_nxt;
            phase_r <= !phase_r;
        end
    end

    decade_scaler u_scale (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick_in(tb_1m),
        .ticks(dec_ticks)
    );

    // measurement sequencer
    logic [10:0] hold_r, hold_nxt, hold_sum;
    logic clr_cnt, wrap;
    assign gate_open = state_r == interval_pkg::ST_COUNT || ctrl_r.gate_force;
    assign hold_sum = hold_r + {9'h000, inc_sel};

    always_comb begin
        state_nxt = state_r;
        seen_nxt = seen_r;
        hold_nxt = hold_r;
        eoc_p = 1'b0;
        clr_cnt = 1'b0;
        if (clr_any) begin
            state_nxt = interval_pkg::ST_IDLE;
            seen_nxt = 16'h0000;
            hold_nxt = 11'h000;
            clr_cnt = 1'b1;
        end else begin
            case (state_r)
                interval_pkg::ST_IDLE: begin
                    if (start_p) begin
                        state_nxt = interval_pkg::ST_COUNT;
                        seen_nxt = 16'h0001;
                    end
                end
                interval_pkg::ST_COUNT: begin
                    if (stop_p) begin
                        if (is_cont) begin
                            // clear in the stop cycle itself, display takes the pre-clear value
                            eoc_p = 1'b1;
                            clr_cnt = 1'b1;
                            state_nxt = interval_pkg::ST_HOLD;
                            hold_nxt = 11'h000;
                        end else if (is_mult && seen_r < nint_eff) begin
                            seen_nxt = seen_r + 16'h0001;
                        end else begin
                            eoc_p = 1'b1;
                            state_nxt = interval_pkg::ST_DONE;
                        end
                    end
                end
                interval_pkg::ST_DONE: begin
                    state_nxt = interval_pkg::ST_DONE;
                end
                interval_pkg::ST_HOLD: begin
                    if (hold_sum >= interval_pkg::HOLD_COUNTS) begin
                        state_nxt = interval_pkg::ST_IDLE;
                        hold_nxt = 11'h000;
                    end else begin
                        hold_nxt = hold_sum;
                    end
                end
                default: state_nxt = interval_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= interval_pkg::ST_IDLE;
            seen_r <= 16'h0000;
            hold_r <= 11'h000;
        end else begin
            state_r <= state_nxt;
            seen_r <= seen_nxt;
            hold_r <= hold_nxt;
        end
    end

    bcd_count8 u_count (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clr(clr_cnt),
        .inc(cnt_inc),
        .count(count_q),
        .wrap(wrap)
    );

    // display and output registers
    logic [31:0] bcd_n_r;
    logic [3:0] sdiv_r, sdiv_nxt;
    logic [1:0] dp_r, dp_nxt;
    logic eoc_r, eoc_n_r, lamp_r, lamp_nxt, tb_r, tb_nxt, sig_r, sig_nxt;
    always_comb begin
        if (clr_any) begin
            disp_nxt = 32'h0000_0000;
        end else if (eoc_p || !ctrl_r.hold_en) begin
            disp_nxt = count_q;
        end else begin
            disp_nxt = disp_r;
        end
        ovf_nxt = wrap || (ovf_r && !clr_any);
        dp_nxt = dp_of(rate_eff, is_ext);
        lamp_nxt = state_nxt == interval_pkg::ST_COUNT || ctrl_nxt.gate_force;
        // time base out only in single and multiple internal modes
        tb_nxt = (!is_ext && !is_cont) ? (tb_r ^ (inc_int != 2'h0)) : 1'b0;
        sdiv_nxt = sdiv_r;
        sig_nxt = 1'b0;
        if (is_mult) begin
            sig_nxt = sig_r;
            if (start_p) begin
                sdiv_nxt = (sdiv_r == interval_pkg::SIG_DIV_LAST) ? 4'h0 : sdiv_r + 4'h1;
                sig_nxt = sig_r ^ (sdiv_r == interval_pkg::SIG_DIV_LAST);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            disp_r <= 32'h0000_0000;
            bcd_n_r <= 32'hffff_ffff;
            ovf_r <= 1'b0;
            dp_r <= 2'h2;
            eoc_r <= 1'b0;
            eoc_n_r <= 1'b1;
            lamp_r <= 1'b0;
            tb_r <= 1'b0;
            sdiv_r <= 4'h0;
            sig_r <= 1'b0;
        end else begin
            disp_r <= disp_nxt;
            bcd_n_r <= ~disp_nxt;
            ovf_r <= ovf_nxt;
            dp_r <= dp_nxt;
            eoc_r <= eoc_p;
            eoc_n_r <= !eoc_p;
            lamp_r <= lamp_nxt;
            tb_r <= tb_nxt;
            sdiv_r <= sdiv_nxt;
            sig_r <= sig_nxt;
        end
    end

    assign bcd_out = disp_r;
    assign bcd_out_n = bcd_n_r;
    assign dp_out = dp_r;
    assign eoc = eoc_r;
    assign eoc_n = eoc_n_r;
    assign gate_lamp = lamp_r;
    assign rst_inhibit = lamp_r;
    assign tb_out = tb_r;
    assign sig_scaled_out = sig_r;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    single_stop_a: assert property (
        (state_r == interval_pkg::ST_COUNT && is_single && stop_p && !clr_any)
        |=> state_r == interval_pkg::ST_DONE && eoc) else $error("single stop did not end count");
    ext_count_a: assert property (
        (is_ext && gate_open) |-> cnt_inc == (eoc_p ? 2'h0 : {1'b0, ext_edge})) else $error("external tick mismatch");
    split_stop_a: assert property (
        (state_r == interval_pkg::ST_COUNT && is_single && ctrl_r.sel == interval_pkg::SEL_BC
         && !pin_rise[1] && !clr_any) |=> state_r == interval_pkg::ST_COUNT)
        else $error("split mode stopped without c pulse");
    mult_step_a: assert property (
        (state_r == interval_pkg::ST_COUNT && is_mult && stop_p && seen_r < nint_eff && !clr_any)
        |=> state_r == interval_pkg::ST_COUNT && seen_r == $past(seen_r) + 16'h0001)
        else $error("multiple interval step wrong");
    cont_reset_a: assert property (
        (state_r == interval_pkg::ST_COUNT && is_cont && stop_p && !clr_any)
        |=> state_r == interval_pkg::ST_HOLD && count_q == 32'h0000_0000 && eoc)
        else $error("continuous stop did not reset");
    holdoff_bound_a: assert property (
        state_r == interval_pkg::ST_HOLD |-> hold_r < interval_pkg::HOLD_COUNTS)
        else $error("holdoff overran");
    holdoff_wait_a: assert property (
        (state_r == interval_pkg::ST_HOLD && !clr_any && hold_sum < interval_pkg::HOLD_COUNTS)
        |=> state_r == interval_pkg::ST_HOLD) else $error("gate reopened early");
    done_stable_a: assert property (
        (state_r == interval_pkg::ST_DONE && !clr_any && !ctrl_r.gate_force)
        |=> $stable(count_q) && state_r == interval_pkg::ST_DONE) else $error("held result changed");
    clear_zero_a: assert property (
        clr_any |=> count_q == 32'h0000_0000 && disp_r == 32'h0000_0000 && state_r == interval_pkg::ST_IDLE)
        else $error("clear did not zero result");
    gate_lamp_a: assert property (
        gate_lamp == gate_open) else $error("gate lamp out of step");
    hold_disp_a: assert property (
        (ctrl_r.hold_en && !eoc_p && !clr_any) |=> $stable(disp_r)) else $error("held display moved");
    compl_out_a: assert property (
        bcd_out_n == ~bcd_out && eoc_n == !eoc) else $error("secondary output not complement");

    single_done_c: cover property (state_r == interval_pkg::ST_COUNT && is_single ##1 eoc);
    mult_done_c: cover property (is_mult && eoc && nint_eff > 16'h0001);
    cont_reopen_c: cover property (state_r == interval_pkg::ST_HOLD ##1 state_r == interval_pkg::ST_IDLE);
    ext_tick_c: cover property (is_ext && cnt_inc != 2'h0);
endmodule

// file: rtl/interval_pkg.sv
// shared constants, types and register map of the interval timer
package interval_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int TB_HZ = 1_000_000;
    localparam int FAST_HZ = 10_000_000;
    localparam int TB_DIV = CLK_HZ / TB_HZ;
    localparam int FAST_DIV = CLK_HZ / FAST_HZ;
    localparam logic [5:0] TB_DIV_LAST = 6'(TB_DIV - 1);
    localparam logic [1:0] FAST_DIV_LAST = 2'(FAST_DIV - 1);
    localparam logic [10:0] HOLD_COUNTS = 11'h3e8;

    localparam int DIG_N = 8;
    localparam int DEC_N = 6;
    localparam int CTRL_W = 12;

    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_NINT = 5'h04;
    localparam logic [4:0] OFS_CMD = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0c;
    localparam logic [4:0] OFS_COUNT = 5'h10;
    localparam logic [4:0] OFS_DISP = 5'h14;

    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h800;
    localparam logic [15:0] NINT_RST = 16'h0001;
    localparam logic [3:0] RATE_MAX = 4'h8;
    localparam logic [3:0] MULT_RATE_MAX = 4'h2;
    localparam logic [3:0] SIG_DIV_LAST = 4'h9;
    localparam logic [1:0] DP_NONE = 2'h3;

    localparam logic [1:0] SEL_B = 2'h0;
    localparam logic [1:0] SEL_C = 2'h1;
    localparam logic [1:0] SEL_BC = 2'h2;

    typedef enum logic [2:0] {
        MODE_SINGLE_INT = 3'b000,
        MODE_SINGLE_EXT = 3'b001,
        MODE_MULT_INT = 3'b010,
        MODE_MULT_EXT = 3'b011,
        MODE_CONT_INT = 3'b100,
        MODE_CONT_EXT = 3'b101
    } mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_DONE = 2'b10,
        ST_HOLD = 2'b11
    } state_e;

    // control word, msb first: hold, gate force, ref source, rate, select, mode
    typedef struct packed {
        logic hold_en;
        logic gate_force;
        logic ref_ext;
        logic [3:0] rate;
        logic [1:0] sel;
        logic [2:0] mode;
    } ctrl_s;

endpackage

// file: rtl/bcd_count8.sv
// eight cascaded bcd decades with a small increment into the lowest digit
`timescale 1ns/1ps
module bcd_count8 (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic [1:0] inc,
    output logic [4*interval_pkg::DIG_N-1:0] count,
    output logic wrap
);
    logic [4*interval_pkg::DIG_N-1:0] count_r, count_nxt;
    logic [interval_pkg::DIG_N:1] carry;
    logic [4:0] sum0;

    assign sum0 = {1'b0, count_r[3:0]} + {3'b000, inc};
    assign carry[1] = sum0 >= 5'h0a;
    assign count_nxt[3:0] = clr ? 4'h0 : carry[1] ? 4'(sum0 - 5'h0a) : sum0[3:0];

    genvar i;
    for (i = 1; i < interval_pkg::DIG_N; i++) begin : g_dig
        assign carry[i+1] = carry[i] && count_r[4*i+:4] == 4'h9;
        assign count_nxt[4*i+:4] = clr ? 4'h0 :
            !carry[i] ? count_r[4*i+:4] :
            carry[i+1] ? 4'h0 : count_r[4*i+:4] + 4'h1;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
    // a carry in the clear cycle is still reported, so the sticky overflow sees it
    assign wrap = carry[interval_pkg::DIG_N];
endmodule

// file: rtl/decade_scaler.sv
// decade divider chain: one-cycle ticks at 1/10^k of the input tick rate
`timescale 1ns/1ps
module decade_scaler (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic tick_in,
    output logic [interval_pkg::DEC_N:0] ticks
);
    assign ticks[0] = tick_in;

    genvar k;
    for (k = 0; k < interval_pkg::DEC_N; k++) begin : g_dec
        logic [3:0] cnt_r, cnt_nxt;
        always_comb begin
            cnt_nxt = cnt_r;
            if (ticks[k]) begin
                cnt_nxt = (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
            end
        end
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_nxt;
            end
        end
        assign ticks[k+1] = ticks[k] && cnt_r == 4'h9;
    end
endmodule

// file: tb/marker_src.sv
// marker pulse source, external clock source and bcd recorder
`timescale 1ns/1ps
module marker_src (
    input wire logic mclk,
    input wire logic eoc,
    input wire logic [31:0] bcd_out,
    output logic marker_b,
    output logic marker_c,
    output logic ext_clk,
    output logic ext_ref,
    output logic [31:0] rec_val
);
    initial begin
        marker_b = 1'b0;
        marker_c = 1'b0;
        ext_clk = 1'b0;
        ext_ref = 1'b0;
        rec_val = 32'h0000_0000;
    end
    // held three cycles so the synchroniser never misses a pulse
    task automatic pulse(input logic ch);
        @(posedge mclk);
        marker_b <= !ch;
        marker_c <= ch;
        repeat (3) @(posedge mclk);
        marker_b <= 1'b0;
        marker_c <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
    // counted clock or time base reference; both stand low between bursts
    task automatic clocks(input int n, input logic to_ref = 1'b0);
        repeat (n) begin
            @(posedge mclk);
            ext_clk <= !to_ref;
            ext_ref <= to_ref;
            repeat (2) @(posedge mclk);
            ext_clk <= 1'b0;
            ext_ref <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask
    always @(posedge mclk) begin
        if (eoc === 1'b1) begin
            rec_val <= bcd_out;
        end
    end
endmodule

// file: tb/tb_top.sv
// self-checking bench of the interval timer
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] sel;
        logic [3:0] nint;
        logic st;
        logic sp;
        logic [7:0] k;
        logic [31:0] exp;
    } row_s;
    logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, marker_b, marker_c, ext_clk, ext_ref, clear_req;
    logic eoc, eoc_n, rst_inhibit, gate_lamp, tb_out, sig_scaled_out, tb_prev;
    logic [4:0] avs_address;
    logic [1:0] dp_out;
    logic [31:0] avs_writedata, avs_readdata, bcd_out, bcd_out_n, rec_val, rdv;
    int mismatches = 0;
    int num_checks = 0;
    int toggles = 0;
    int t0;
    // lowest count per multiple rate over 407 gated cycles; phase adds at most one
    logic [31:0] count_lo [3] = '{32'h0000_1017, 32'h0000_0101, 32'h0000_0010};
    row_s r;
    row_s rows [5] = '{
        '{interval_pkg::MODE_SINGLE_EXT, interval_pkg::SEL_B, 4'h1, 1'b0, 1'b0, 8'h05, 32'h0000_0005},
        '{interval_pkg::MODE_SINGLE_EXT, interval_pkg::SEL_C, 4'h1, 1'b1, 1'b1, 8'h0c, 32'h0000_0012},
        '{interval_pkg::MODE_SINGLE_EXT, interval_pkg::SEL_BC, 4'h1, 1'b0, 1'b1, 8'h07, 32'h0000_0007},
        '{interval_pkg::MODE_MULT_EXT, interval_pkg::SEL_C, 4'h2, 1'b1, 1'b1, 8'h06, 32'h0000_0012},
        '{interval_pkg::MODE_MULT_EXT, interval_pkg::SEL_B, 4'h3, 1'b0, 1'b0, 8'h04, 32'h0000_0012}};

    zero_crossing_interval_timer zero_crossing_interval_timer_inst (.mclk, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .marker_b, .marker_c, .ext_clk,
        .ext_ref, .clear_req, .bcd_out, .dp_out, .rst_inhibit, .eoc, .bcd_out_n, .eoc_n, .gate_lamp,
        .tb_out, .sig_scaled_out);
    marker_src marker_src_inst (.mclk, .eoc, .bcd_out, .marker_b, .marker_c, .ext_clk, .ext_ref, .rec_val);

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        tb_prev <= tb_out;
        if (tb_out !== tb_prev) toggles <= toggles + 1;
    end

    function automatic logic [31:0] ctl(input logic hold, input logic frc, input logic [3:0] rate,
                                        input logic [1:0] sel, input logic [2:0] mode);
        return {20'h0_0000, hold, frc, 1'b0, rate, sel, mode};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) mismatches++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    initial begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0000_0000;
        clear_req = 1'b0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        chk(bcd_out_n, 32'hffff_ffff);
        chk(32'(eoc_n), 32'h0000_0001);
        bus(1'b0, interval_pkg::OFS_CTRL, 32'h0000_0000, rdv);
        chk(rdv, 32'h0000_0800);
        bus(1'b0, 5'h18, 32'h0000_0000, rdv);
        chk(rdv, 32'h0000_0000);
        $display("reset test done");
        foreach (rows[i]) begin
            r = rows[i];
            bus(1'b1, interval_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 4'h0, r.sel, r.mode), rdv);
            bus(1'b1, interval_pkg::OFS_NINT, 32'(r.nint), rdv);
            bus(1'b1, interval_pkg::OFS_CMD, 32'h0000_0001, rdv);
            if (r.st != r.sp) marker_src_inst.pulse(r.sp);
            marker_src_inst.pulse(r.st);
            for (int j = 1; j <= r.nint; j++) begin
                marker_src_inst.clocks(r.k);
                chk(32'(gate_lamp), 32'h0000_0001);
                marker_src_inst.pulse(j == r.nint ? r.sp : r.st);
            end
            chk(bcd_out, r.exp);
            chk(bcd_out_n, ~r.exp);
            chk(rec_val, r.exp);
            chk(32'(dp_out), 32'h0000_0003);
            $display("row %0d done", i);
        end
        marker_src_inst.pulse(1'b0);
        marker_src_inst.clocks(3);
        chk(bcd_out, 32'h0000_0012);
        bus(1'b1, interval_pkg::OFS_CMD, 32'h0000_0001, rdv);
        repeat (2) @(posedge mclk);
        chk(bcd_out, 32'h0000_0000);
        bus(1'b1, interval_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 4'h0, interval_pkg::SEL_B, 3'h1), rdv);
        marker_src_inst.pulse(1'b0);
        marker_src_inst.clocks(3);
        repeat (2) @(posedge mclk);
        chk(bcd_out, 32'h0000_0003);
        chk(32'(rst_inhibit), 32'h0000_0001);
        clear_req <= 1'b1;
        repeat (4) @(posedge mclk);
        clear_req <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(bcd_out, 32'h0000_0000);
        bus(1'b1, interval_pkg::OFS_CTRL, ctl(1'b1, 1'b1, 4'h0, interval_pkg::SEL_B, 3'h1), rdv);
        repeat (2) @(posedge mclk);
        chk(32'(gate_lamp), 32'h0000_0001);
        $display("clear and gate tests done");
        bus(1'b1, interval_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 4'h3, interval_pkg::SEL_B, 3'h0) | 32'h0000_0200, rdv);
        bus(1'b1, interval_pkg::OFS_CMD, 32'h0000_0001, rdv);
        marker_src_inst.pulse(1'b0);
        marker_src_inst.clocks(30, 1'b1);
        marker_src_inst.pulse(1'b0);
        chk(bcd_out, 32'h0000_0003);
        $display("reference test done");
        bus(1'b1, interval_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 4'h0, interval_pkg::SEL_B, 3'h5), rdv);
        bus(1'b1, interval_pkg::OFS_CMD, 32'h0000_0001, rdv);
        marker_src_inst.pulse(1'b0);
        marker_src_inst.clocks(4);
        marker_src_inst.pulse(1'b0);
        chk(bcd_out, 32'h0000_0004);
        bus(1'b0, interval_pkg::OFS_COUNT, 32'h0000_0000, rdv);
        chk(rdv, 32'h0000_0000);
        marker_src_inst.pulse(1'b0);
        marker_src_inst.clocks(999);
        repeat (4) @(posedge mclk);
        bus(1'b0, interval_pkg::OFS_STAT, 32'h0000_0000, rdv);
        chk(32'(rdv[1:0]), 32'h0000_0003);
        marker_src_inst.clocks(1);
        repeat (4) @(posedge mclk);
        bus(1'b0, interval_pkg::OFS_STAT, 32'h0000_0000, rdv);
        chk(32'(rdv[1:0]), 32'h0000_0000);
        marker_src_inst.pulse(1'b0);
        marker_src_inst.clocks(2);
        marker_src_inst.pulse(1'b0);
        chk(bcd_out, 32'h0000_0002);
        $display("continuous test done");
        bus(1'b1, interval_pkg::OFS_NINT, 32'h0000_0001, rdv);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, interval_pkg::OFS_CTRL, ctl(1'b1, 1'b0, 4'(k), interval_pkg::SEL_B, 3'h2), rdv);
            bus(1'b1, interval_pkg::OFS_CMD, 32'h0000_0001, rdv);
            t0 = toggles;
            marker_src_inst.pulse(1'b0);
            repeat (400) @(posedge mclk);
            marker_src_inst.pulse(1'b0);
            chk(32'(dp_out), 32'(2 - k));
            chk(32'(bcd_out - count_lo[k] <= 32'h0000_0001), 32'h0000_0001);
        end
        chk(32'(bcd_out inside {32'h0000_0009, 32'h0000_0010, 32'h0000_0011}), 32'h0000_0001);
        chk(32'((toggles - t0) inside {[8:12]}), 32'h0000_0001);
        chk(32'(sig_scaled_out), 32'h0000_0001);
        $display("multiple internal test done");
        conclude();
    end
endmodule
